// ==== rtl/fst_map.vh ====
`ifndef FST_MAP_VH
`define FST_MAP_VH
// ----------------------------------------------------------------
// Register addresses (3-bit register index)
// ----------------------------------------------------------------
`define FST_A_CTRL0 3'h0
`define FST_A_CTRL2 3'h2
`define FST_A_CTRL3 3'h3
`define FST_A_STAT0 3'h4
`define FST_A_STAT1 3'h5
`define FST_A_STAT2 3'h6
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FST_B_SWREQ 6
`define FST_B_TWAR 4
`define FST_B_STAT_TWAR 2
`define FST_B_STAT_SW_DEV_SELECT_PIN 5
`define FST_B_STAT_CFG 4
`define FST_B_STAT_FSM 11
`define FST_B_STAT_REQ 10
// ----------------------------------------------------------------
// Cause flag codes
// ----------------------------------------------------------------
`define FST_C_TSD 2'h0
`define FST_C_UV 2'h1
`define FST_C_RSTL 2'h2
`define FST_C_WD 2'h3
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define FST_RST12 12'h000
`define FST_CLK_HZ 50000000
`define FST_SLOW_HZ_X100 125
`define FST_FAST_HZ 100
`define FST_SLOW_HALF ((`FST_CLK_HZ / `FST_SLOW_HZ_X100) * 50)
`define FST_FAST_PER (`FST_CLK_HZ / `FST_FAST_HZ)
`define FST_FAST_LOW (`FST_FAST_PER / 5)
`endif

// ==== rtl/fst_failsafe_thermal.v ====
// Behaviour
// - Warning flag sets on each threshold crossing
// - Status bit shows live warning comparison
// - Unmasked warning flag raises interrupt request
// - Shutdown threshold exceeded enters fail-safe mode
// - Thermal fail-safe ignores wakeups, exits below warning
// - Monitoring only in supply-on or thermal fail-safe
// - One request drives all outputs; static held low
// - Slow output 1.25 Hz, 50 percent duty
// - Fast output 100 Hz, 20 percent duty
// - Request asserts immediately on failure or software
// - Development config ignores watchdog and reset-low failures
// - Software request clears by writing zero or in configuration mode
// - Failure request clears on cause flag read-clear
// - Start-up lockout allows only mode/watchdog writes
// - Rejected lockout accesses have no effect
// - Supply undervoltage requests without fail-safe entry
// - Reset clamped low: enter fail-safe in configs 2,4
// - Watchdog miss policy per configuration 1 to 4
// - Software request in active modes, no fail-safe entry
// - Policy pins latched only in configuration mode
// - Development pin latched high overrides policy pin
// - Reset mode clears the warning flag and masks events
//
// The implementer's own choices: the register addresses and the strobed register port.
`include "fst_map.vh"
`default_nettype none
module fst_failsafe_thermal (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register port
  input wire [2:0] reg_addr,
  input wire [11:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [11:0] reg_rdata,
  // Mode indications from the state controller
  input wire mode_config,
  input wire mode_powerup,
  input wire mode_reset,
  input wire mode_startup,
  input wire mode_normal,
  input wire mode_standby,
  input wire mode_flash,
  // Analog comparators and pins (asynchronous)
  input wire warning_threshold,
  input wire shutdown_threshold,
  input wire sw_dev_select_pin,
  input wire cfg_pin,
  // Failure and wakeup events from other blocks (same clock)
  input wire supply_uv_event,
  input wire reset_pin_low_event,
  input wire watchdog_miss_event,
  input wire wakeup_event,
  // Status and interrupt
  output reg thermal_warning_flag,
  output reg thermal_warning_status,
  output reg irq_request,
  output reg failsafe_request,
  output reg failsafe_mode,
  output reg wakeup_accepted,
  // Open-drain fail-safe outputs (enable high pulls low)
  output reg failsafe_out_static_o,
  output reg failsafe_out_static_oe,
  output reg failsafe_out_slow_o,
  output reg failsafe_out_slow_oe,
  output reg failsafe_out_fast_o,
  output reg failsafe_out_fast_oe
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
reg [3:0] sync1_r;
reg [3:0] sync2_r;
reg [3:0] sync3_r;
reg [3:0] clean_r;
// Bit order: warning, shutdown, development select, policy
wire [3:0] raw_in;
assign raw_in = {cfg_pin, sw_dev_select_pin, shutdown_threshold,
                 warning_threshold};

// Three stages; a level counts once stages two and three agree
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
    always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        sync1_r[gi] <= 1'b0;
        sync2_r[gi] <= 1'b0;
        sync3_r[gi] <= 1'b0;
        clean_r[gi] <= 1'b0;
      end else begin
        sync1_r[gi] <= raw_in[gi];
        sync2_r[gi] <= sync1_r[gi];
        sync3_r[gi] <= sync2_r[gi];
        if (sync2_r[gi] == sync3_r[gi]) begin
          clean_r[gi] <= sync3_r[gi];
        end
      end
    end
  end
endgenerate

wire warn_hi = clean_r[0];
wire sd_hi = clean_r[1];
wire sw_dev_select_pin_in = clean_r[2];
wire cfg_in = clean_r[3];

// ----------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------
reg [11:0] ctrl0_r;
reg [11:0] ctrl2_r;
reg [11:0] ctrl3_r;
reg [3:0] cause_r;
reg sw_dev_select_pin_r;
reg cfg_r;
reg tsd_fs_r;
reg fail_req_r;
reg [1:0] wd_miss_r;
reg warn_prev_r;

wire sw_req = ctrl2_r[`FST_B_SWREQ];
wire sw_dev = sw_dev_select_pin_r;
wire fs_active = sw_req | fail_req_r;
// Lockout forces one good watchdog service after a failure
wire lockout = mode_startup & fs_active;

// Monitor runs where the main supply output is on
wire monitor_on = mode_powerup | mode_reset | mode_startup |
                  mode_normal | mode_standby | mode_flash |
                  tsd_fs_r;

// Lockout blocks every write except the mode/watchdog register
wire wr_ok = reg_wr & (~lockout | (reg_addr == `FST_A_CTRL0));
wire rc_stat1 = reg_wr & ~lockout &
                (reg_addr == `FST_A_STAT1);
wire rc_stat0 = reg_wr & ~lockout & (reg_addr == `FST_A_STAT0);

// Policy decoding; development config drops watchdog and reset-low
wire rstl_ev = reset_pin_low_event & ~sw_dev;
wire wd_ev = watchdog_miss_event & ~sw_dev;
wire rstl_enter = rstl_ev & cfg_r;
wire wd_first = (wd_miss_r == 2'h0);
wire wd_enter = wd_ev & cfg_r & ~wd_first;
wire tsd_ev = monitor_on & sd_hi & ~tsd_fs_r;
wire uv_ev = supply_uv_event;
// One bit per cause; a read-clear drops them all at once
wire [3:0] new_cause;
assign new_cause = (4'h1 << `FST_C_TSD) & {4{tsd_ev}} |
                   (4'h1 << `FST_C_UV) & {4{uv_ev}} |
                   (4'h1 << `FST_C_RSTL) & {4{rstl_ev}} |
                   (4'h1 << `FST_C_WD) & {4{wd_ev}};

// ----------------------------------------------------------------
// Strap latch
// ----------------------------------------------------------------
// Caught only in configuration mode, frozen afterwards
// Pins must settle through the synchroniser before config ends
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    sw_dev_select_pin_r <= 1'b0;
    cfg_r <= 1'b0;
  end else if (mode_config) begin
    sw_dev_select_pin_r <= sw_dev_select_pin_in;
    cfg_r <= cfg_in;
  end
end

// ----------------------------------------------------------------
// Control registers
// ----------------------------------------------------------------
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    ctrl0_r <= `FST_RST12;
    ctrl2_r <= `FST_RST12;
    ctrl3_r <= `FST_RST12;
  end else begin
    if (wr_ok && reg_addr == `FST_A_CTRL0) begin
      ctrl0_r <= reg_wdata;
    end
    // Software request bit changes by an explicit write and clears in configuration mode
    if (mode_config) begin
      ctrl2_r <= `FST_RST12;
    end else if (wr_ok && reg_addr == `FST_A_CTRL2) begin
      ctrl2_r <= reg_wdata;
    end
    // Reset mode masks every maskable event
    if (mode_reset) begin
      ctrl3_r <= `FST_RST12;
    end else if (wr_ok && reg_addr == `FST_A_CTRL3) begin
      ctrl3_r <= reg_wdata;
    end
  end
end

// ----------------------------------------------------------------
// Thermal monitoring
// ----------------------------------------------------------------
// Edge of the comparator sets the flag; set beats read-clear
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    warn_prev_r <= 1'b0;
    thermal_warning_status <= 1'b0;
    thermal_warning_flag <= 1'b0;
    irq_request <= 1'b0;
  end else begin
    if (monitor_on) begin
      warn_prev_r <= warn_hi;
      thermal_warning_status <= warn_hi;
    end
    irq_request <= 1'b0;
    if (monitor_on && warn_hi != warn_prev_r) begin
      thermal_warning_flag <= 1'b1;
      irq_request <= ctrl3_r[`FST_B_TWAR];
    end else if (mode_reset || rc_stat0) begin
      thermal_warning_flag <= 1'b0;
    end
  end
end

// ----------------------------------------------------------------
// Fail-safe request and mode
// ----------------------------------------------------------------
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    cause_r <= 4'h0;
    fail_req_r <= 1'b0;
    tsd_fs_r <= 1'b0;
    wd_miss_r <= 2'h0;
    failsafe_mode <= 1'b0;
  end else begin
    // New causes win over a read-clear in the same cycle
    if (new_cause != 4'h0) begin
      cause_r <= (rc_stat1 ? 4'h0 : cause_r) | new_cause;
      fail_req_r <= 1'b1;
    end else if (rc_stat1) begin
      cause_r <= 4'h0;
      fail_req_r <= 1'b0;
    end else if (mode_config) begin
      cause_r <= 4'h0;
    end
    // Miss counter tells first from second watchdog miss
    if (wd_ev && wd_miss_r != 2'h2) begin
      wd_miss_r <= wd_miss_r + 2'h1;
    end else if (mode_normal && !wd_ev) begin
      wd_miss_r <= 2'h0;
    end
    // Thermal fail-safe leaves only when below warning level
    // Other fail-safe causes leave on a wakeup instead
    if (tsd_ev) begin
      tsd_fs_r <= 1'b1;
      failsafe_mode <= 1'b1;
    end else if (tsd_fs_r && !warn_hi) begin
      tsd_fs_r <= 1'b0;
      failsafe_mode <= 1'b0;
    end else if (rstl_enter || wd_enter) begin
      failsafe_mode <= 1'b1;
    end else if (!tsd_fs_r && wakeup_event) begin
      failsafe_mode <= 1'b0;
    end
  end
end

// Wakeups pass only outside thermal fail-safe
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    wakeup_accepted <= 1'b0;
  end else begin
    wakeup_accepted <= wakeup_event & ~tsd_fs_r;
  end
end

// ----------------------------------------------------------------
// Waveform generators
// ----------------------------------------------------------------
reg [24:0] slow_cnt_r;
reg slow_ph_r;
reg [19:0] fast_cnt_r;
// Full-width counts first, then trimmed to the counter widths
localparam [31:0] SLOW_HALF_W = `FST_SLOW_HALF;
localparam [31:0] FAST_PER_W = `FST_FAST_PER;
localparam [31:0] FAST_LOW_W = `FST_FAST_LOW;
localparam [24:0] SLOW_HALF = SLOW_HALF_W[24:0];
localparam [19:0] FAST_PER = FAST_PER_W[19:0];
localparam [19:0] FAST_LOW = FAST_LOW_W[19:0];

// Limitation: periods assume the 50 MHz clock
// Counters held at start phase while idle
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    slow_cnt_r <= 25'h0000000;
    slow_ph_r <= 1'b0;
    fast_cnt_r <= 20'h00000;
  end else if (!fs_active) begin
    slow_cnt_r <= 25'h0000000;
    slow_ph_r <= 1'b0;
    fast_cnt_r <= 20'h00000;
  end else begin
    if (slow_cnt_r == SLOW_HALF - 25'h0000001) begin
      slow_cnt_r <= 25'h0000000;
      slow_ph_r <= ~slow_ph_r;
    end else begin
      slow_cnt_r <= slow_cnt_r + 25'h0000001;
    end
    if (fast_cnt_r == FAST_PER - 20'h00001) begin
      fast_cnt_r <= 20'h00000;
    end else begin
      fast_cnt_r <= fast_cnt_r + 20'h00001;
    end
  end
end

// Output drivers: enable high pulls the pin low
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    failsafe_request <= 1'b0;
    failsafe_out_static_oe <= 1'b0;
    failsafe_out_slow_oe <= 1'b0;
    failsafe_out_fast_oe <= 1'b0;
    failsafe_out_static_o <= 1'b0;
    failsafe_out_slow_o <= 1'b0;
    failsafe_out_fast_o <= 1'b0;
  end else begin
    failsafe_request <= fs_active;
    failsafe_out_static_oe <= fs_active;
    failsafe_out_slow_oe <= fs_active & ~slow_ph_r;
    failsafe_out_fast_oe <= fs_active &
                            (fast_cnt_r < FAST_LOW);
    failsafe_out_static_o <= 1'b0;
    failsafe_out_slow_o <= 1'b0;
    failsafe_out_fast_o <= 1'b0;
  end
end

// ----------------------------------------------------------------
// Register read port
// ----------------------------------------------------------------
reg [11:0] rd_mux;
always @* begin
  rd_mux = 12'h000;
  case (reg_addr)
    `FST_A_CTRL0: rd_mux = ctrl0_r;
    `FST_A_CTRL2: rd_mux = ctrl2_r;
    `FST_A_CTRL3: rd_mux = ctrl3_r;
    `FST_A_STAT0: rd_mux[`FST_B_TWAR] = thermal_warning_flag;
    `FST_A_STAT1: rd_mux = {4'h0, cause_r, 4'h0};
    `FST_A_STAT2: begin
      rd_mux[`FST_B_STAT_TWAR] = thermal_warning_status;
      rd_mux[`FST_B_STAT_SW_DEV_SELECT_PIN] = sw_dev_select_pin_r;
      rd_mux[`FST_B_STAT_CFG] = cfg_r;
      rd_mux[`FST_B_STAT_FSM] = failsafe_mode;
      rd_mux[`FST_B_STAT_REQ] = fs_active;
    end
    default: rd_mux = 12'h000;
  endcase
end

// Read data valid the cycle after the strobe only
// Zero elsewhere, so a stale word is never taken for an answer
always @(posedge clk or negedge resetn) begin
  if (!resetn) begin
    reg_rdata <= 12'h000;
  end else if (reg_rd) begin
    reg_rdata <= rd_mux;
  end else begin
    reg_rdata <= 12'h000;
  end
end

endmodule
`default_nettype wire

// ==== tb/fst_chk_properties.sv ====
`default_nettype none
module fst_chk (
  // Clock, reset, bus and modes
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [11:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic mode_startup,
  input wire logic mode_standby,
  // Events and outputs
  input wire logic supply_uv_event,
  input wire logic thermal_warning_flag,
  input wire logic thermal_warning_status,
  input wire logic irq_request,
  input wire logic failsafe_request,
  input wire logic failsafe_out_static_o,
  input wire logic failsafe_out_static_oe,
  input wire logic failsafe_out_slow_oe,
  input wire logic failsafe_out_fast_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Output pins follow the single request
  // ------------------------------------------------------------
  req_static_low_a: assert property (failsafe_request |->
    failsafe_out_static_oe) else $error("static output not pulled");
  drive_level_a: assert property (failsafe_out_static_oe |->
    !failsafe_out_static_o) else $error("driven level not low");
  idle_release_a: assert property (!failsafe_request &&
    !$past(failsafe_request) |-> !(failsafe_out_static_oe ||
    failsafe_out_slow_oe || failsafe_out_fast_oe))
    else $error("outputs pulled while idle");
  phase_start_a: assert property ($rose(failsafe_request) |->
    failsafe_out_slow_oe && failsafe_out_fast_oe)
    else $error("waveforms not at start phase");
  // ------------------------------------------------------------
  // Request sources, the start-up lockout and the warning flag
  // ------------------------------------------------------------
  sw_request_a: assert property (reg_wr && reg_addr == 3'h2 &&
    reg_wdata[6] && mode_standby && !mode_startup |-> ##2
    failsafe_request) else $error("software request missed");
  lockout_hold_a: assert property (mode_startup && reg_wr &&
    failsafe_request && reg_addr == 3'h2 |-> ##2 failsafe_request)
    else $error("locked write cleared request");
  uv_request_a: assert property (supply_uv_event |-> ##[1:3]
    failsafe_request) else $error("undervoltage request missed");
  irq_cause_a: assert property (irq_request |-> ##[0:1]
    thermal_warning_flag) else $error("interrupt without flag");
  status_flag_a: assert property ($changed(thermal_warning_status)
    |-> ##[0:2] thermal_warning_flag) else $error("crossing not flagged");
  cover property ($rose(failsafe_request));
  cover property (irq_request);
  cover property (mode_startup && failsafe_request && reg_wr);
endmodule
bind fst_failsafe_thermal fst_chk i_chk (.clk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .mode_startup, .mode_standby, .supply_uv_event,
  .thermal_warning_flag, .thermal_warning_status, .irq_request,
  .failsafe_request, .failsafe_out_static_o, .failsafe_out_static_oe,
  .failsafe_out_slow_oe, .failsafe_out_fast_oe);
`default_nettype wire

// ==== tb/fst_fs_circuit.sv ====
`default_nettype none
module fst_fs_circuit (
  // Open-drain drivers from the block
  input wire logic [2:0] oe,
  input wire logic [2:0] o,
  // Pin levels seen by the external circuit
  output logic [2:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups win when released, so no level is ever left floating
  assign pin = (oe & o) | ~oe;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [11:0] reg_wdata = 12'h000, v, cv;
  logic cfg_l;
  logic mode_config = 1, mode_powerup = 0, mode_reset = 0;
  logic mode_startup = 0, mode_normal = 0, mode_standby = 0;
  logic mode_flash = 0, warning_threshold = 0, shutdown_threshold = 0;
  logic sw_dev_select_pin = 0, cfg_pin = 0, supply_uv_event = 0;
  logic reset_pin_low_event = 0, watchdog_miss_event = 0;
  logic wakeup_event = 0;
  wire [11:0] reg_rdata;
  wire twf, tws, irq, req, fsm, wacc;
  wire [2:0] od_o, od_oe, pin;
  int failures = 0, check_count = 0, irqs = 0, wakes = 0;
  fst_failsafe_thermal i_dut (.clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mode_config, .mode_powerup,
    .mode_reset, .mode_startup, .mode_normal, .mode_standby,
    .mode_flash, .warning_threshold, .shutdown_threshold,
    .sw_dev_select_pin, .cfg_pin, .supply_uv_event,
    .reset_pin_low_event, .watchdog_miss_event, .wakeup_event,
    .thermal_warning_flag(twf), .thermal_warning_status(tws),
    .irq_request(irq), .failsafe_request(req), .failsafe_mode(fsm),
    .wakeup_accepted(wacc), .failsafe_out_static_o(od_o[0]),
    .failsafe_out_static_oe(od_oe[0]), .failsafe_out_slow_o(od_o[1]),
    .failsafe_out_slow_oe(od_oe[1]), .failsafe_out_fast_o(od_o[2]),
    .failsafe_out_fast_oe(od_oe[2]));
  fst_fs_circuit i_fsc (.oe(od_oe), .o(od_o), .pin(pin));
  initial begin
    forever #10 clk = ~clk;
  end
  // Pulse counters, since both outputs stand a single cycle
  always @(posedge clk) begin
    irqs <= irqs + irq;
    wakes <= wakes + wacc;
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [11:0] d);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  // Event pulse: 0 uv, 1 watchdog, 2 wakeup, 3 reset low, 4 reset mode
  task automatic pulse(input int k);
    @(posedge clk);
    {mode_reset, reset_pin_low_event, wakeup_event, watchdog_miss_event,
      supply_uv_event} <= 5'h01 << k;
    @(posedge clk);
    {mode_reset, reset_pin_low_event, wakeup_event, watchdog_miss_event,
      supply_uv_event} <= 5'h00;
    tick(3);
  endtask
  task automatic final_report;
    $display("Checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hC4EB));
    cfg_pin <= 1'($urandom);
    repeat (3) @(posedge clk);
    resetn <= 1;
    tick(8);
    cfg_l = cfg_pin;
    mode_config <= 0;
    mode_standby <= 1;
    sw_dev_select_pin <= 1;
    cfg_pin <= ~cfg_pin;
    tick(8);
    rd(3'h6, v);
    chk(v & 12'h030, {7'h00, cfg_l, 4'h0});
    cv = 12'($urandom);
    wr(3'h0, cv);
    rd(3'h0, v);
    chk(v, cv);
    rd(3'h7, v);
    chk(v, 12'h000);
    wr(3'h3, 12'h010);
    warning_threshold <= 1;
    tick(8);
    rd(3'h6, v);
    chk(v[2], 1'b1);
    rd(3'h4, v);
    chk(v[4], 1'b1);
    chk({twf, tws}, 12'h003);
    wr(3'h4, 12'h000);
    rd(3'h4, v);
    chk(v[4], 1'b0);
    warning_threshold <= 0;
    tick(8);
    rd(3'h4, v);
    chk(v[4], 1'b1);
    chk({twf, tws}, 12'h002);
    chk(irqs[11:0], 12'h002);
    pulse(4);
    rd(3'h4, v);
    chk(v[4], 1'b0);
    rd(3'h3, v);
    chk(v[4], 1'b0);
    wr(3'h2, 12'h040);
    tick(2);
    chk({fsm, req, pin}, 12'h008);
    mode_standby <= 0;
    mode_startup <= 1;
    wr(3'h2, 12'h000);
    wr(3'h0, 12'h5A5);
    tick(2);
    chk(req, 1'b1);
    rd(3'h0, v);
    chk(v, 12'h5A5);
    mode_startup <= 0;
    mode_standby <= 1;
    wr(3'h2, 12'h000);
    tick(2);
    chk({req, pin}, 12'h007);
    pulse(0);
    chk({fsm, req}, 12'h001);
    rd(3'h5, v);
    chk(v[7:4], 4'h2);
    wr(3'h5, 12'h000);
    tick(2);
    chk(req, 1'b0);
    shutdown_threshold <= 1;
    warning_threshold <= 1;
    tick(8);
    chk({fsm, req}, 12'h003);
    pulse(2);
    shutdown_threshold <= 0;
    tick(8);
    chk(fsm, 1'b1);
    chk(wakes[11:0], 12'h000);
    warning_threshold <= 0;
    tick(8);
    chk(fsm, 1'b0);
    wr(3'h5, 12'h000);
    pulse(3);
    chk({fsm, req}, {cfg_l, 1'b1});
    pulse(1);
    chk(req, 1'b1);
    rd(3'h5, v);
    chk(v[7:4], 4'hC);
    wr(3'h5, 12'h000);
    pulse(2);
    chk({fsm, req}, 12'h000);
    // Second miss enters fail-safe only under the entering policy
    pulse(1);
    chk({fsm, req}, {cfg_l, 1'b1});
    wr(3'h5, 12'h000);
    pulse(2);
    // A clean stretch in normal mode makes the next miss a first one
    mode_standby <= 0;
    mode_normal <= 1;
    tick(2);
    pulse(1);
    chk({fsm, req}, 12'h001);
    wr(3'h5, 12'h000);
    mode_normal <= 0;
    mode_config <= 1;
    tick(8);
    mode_config <= 0;
    mode_flash <= 1;
    rd(3'h6, v);
    chk(v & 12'h030, {6'h00, 1'b1, ~cfg_l, 4'h0});
    pulse(1);
    pulse(3);
    chk({fsm, req}, 12'h000);
    final_report;
  end
  // Hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #400000;
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
